// *** tdc_pkg.sv ***
// Constants shared by the input clock phase measurement unit.
// Assumes a single 20 MHz system clock; the measurement clock PLL sits outside.
// Overview of operation
// RQ1 - Measure phase between two selected clocks of equal or integer-related frequency.
// RQ2 - Integer-related clocks report the smallest edge-to-edge difference with its sign.
// RQ3 - Result is first clock minus second; positive means first clock lags.
// RQ4 - Each analog channel has a polarity bit; one inverts the clock.
// RQ5 - Signed 36-bit single result updates once per slower clock period.
// RQ6 - Signed 48-bit sum of 2**(exponent+1) single results at slower rate.
// RQ7 - Each pair has a 4-bit sample exponent, host keeps it at most 11.
// RQ8 - Read-only valid flag rises after the first full sample set.
// RQ9 - Snapshot request rising captures both results together into stable registers.
// RQ10 - Device clears the snapshot request once both results are captured.
// RQ11 - Host polls the request bit to zero before reading results.
// RQ12 - Ten channel power-down bits, zero means powered; all powered after reset.
// RQ13 - Ten pair power-up bits, one enables; all pairs disabled after reset.
// RQ14 - Each pair selects its first clock with a 4-bit code 0 to 9.
// RQ15 - Each pair selects its second clock with a 4-bit code 0 to 9.
// RQ16 - Readout select code 0 to 9 picks which pair feeds the result registers.
// RQ17 - Host raises the apply bit after changing settings; device clears it.
// RQ18 - Device reads back the measurement clock divider value.
// RQ19 - Measurement clock PLL time base selects between two oscillators.
// RQ20 - Ten independent pairs, each comparing any two input clocks.
// RQ21 - Applying settings restarts accumulation and clears valid until a new set.
package tdc_pkg;
  localparam int NUM_CH = 10;
  localparam int NUM_PAIR = 10;
  localparam int SEL_W = 4;
  localparam int EXP_W = 4;
  localparam int SINGLE_W = 36;
  localparam int ACCUM_W = 48;
  localparam int DIV_W = 8;
  localparam int SAMPLE_CNT_W = 13;
  localparam logic [EXP_W-1:0] EXP_MAX = 4'hB;
  localparam logic [DIV_W-1:0] MEAS_DIV_DEFAULT = 8'h10;
  localparam int SYS_CLK_PERIOD_NS = 50;
  localparam real SINGLE_RES_PS = 62.5;
  localparam logic [SEL_W-1:0] SEL_RESET = 4'h0;
  localparam logic [EXP_W-1:0] EXP_RESET = 4'h0;
  localparam logic [NUM_CH-1:0] PDN_RESET = 10'h000;
  localparam logic [NUM_PAIR-1:0] PUP_RESET = 10'h000;
  localparam logic [NUM_CH-1:0] POL_RESET = 10'h000;
endpackage : tdc_pkg

// *** phase_pair_meter.sv ***
// One measurement pair: edge timing of two conditioned clocks, single result and sum.
// Assumes both inputs are already sampled on sys_clk; one count is one sys_clk period.
`timescale 1ns/1ns
`default_nettype none
module phase_pair_meter
  import tdc_pkg::*;
#(
  parameter int MAG_W = SINGLE_W - 1
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Control
  input wire logic pairEnable,
  input wire logic restart,
  input wire logic [EXP_W-1:0] sampleExponent,
  // Conditioned clocks
  input wire logic firstClk,
  input wire logic secondClk,
  // Results
  output logic signed [SINGLE_W-1:0] singleResult,
  output logic signed [ACCUM_W-1:0] accumResult,
  output logic accumValid
);
  // The sign bit sits on top of the magnitude, so the widths must line up
  if (MAG_W != SINGLE_W - 1) begin : g_bad_width
    $error("MAG_W must be one below SINGLE_W");
  end

  logic prevFirst, prevSecond, pending, slowIsFirst, singleStrobe;
  logic [MAG_W-1:0] ageFirst, ageSecond, periodFirst, periodSecond, pendAge, waitCnt;
  logic signed [ACCUM_W-1:0] sum;
  logic [SAMPLE_CNT_W-1:0] sampleCnt;
  wire riseFirst = firstClk & ~prevFirst;
  wire riseSecond = secondClk & ~prevSecond;
  wire firstSlow = periodFirst >= periodSecond;
  wire slowRise = firstSlow ? riseFirst : riseSecond;
  wire fastRise = firstSlow ? riseSecond : riseFirst;
  wire [MAG_W-1:0] ageOther = firstSlow ? ageSecond : ageFirst;
  wire [MAG_W-1:0] afterMag = waitCnt + 1'b1;
  wire pickBefore = pendAge <= afterMag; // [RQ2]
  wire [MAG_W-1:0] mag = pickBefore ? pendAge : afterMag;
  wire positive = slowIsFirst == pickBefore; // [RQ3]
  wire bothRise = slowRise & fastRise;
  wire emit = pairEnable & (bothRise | (fastRise & pending)); // [RQ5]
  wire signed [SINGLE_W-1:0] nextSingle = bothRise ? '0 :
    positive ? $signed({1'b0, mag}) : -$signed({1'b0, mag});
  wire [EXP_W-1:0] expUsed = (sampleExponent > EXP_MAX) ? EXP_MAX : sampleExponent; // [RQ7]
  wire [SAMPLE_CNT_W-1:0] target = SAMPLE_CNT_W'(1) << (expUsed + 1'b1); // [RQ6]
  wire signed [ACCUM_W-1:0] nextSum = sum + ACCUM_W'(nextSingle);
  wire setDone = emit & (sampleCnt + 1'b1 == target);
  wire clearRun = restart | ~pairEnable; // [RQ13] [RQ21]
  wire [MAG_W-1:0] ageMax = '1;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prevFirst <= 1'b0;
      prevSecond <= 1'b0;
      ageFirst <= '1;
      ageSecond <= '1;
      periodFirst <= '0;
      periodSecond <= '0;
    end else begin
      prevFirst <= firstClk;
      prevSecond <= secondClk;
      ageFirst <= riseFirst ? '0 : (ageFirst == ageMax ? ageFirst : ageFirst + 1'b1);
      ageSecond <= riseSecond ? '0 : (ageSecond == ageMax ? ageSecond : ageSecond + 1'b1);
      if (riseFirst) periodFirst <= ageFirst;
      if (riseSecond) periodSecond <= ageSecond;
    end
  end

  // Waiting for the faster clock after each slow edge picks the nearest edge either side
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pending <= 1'b0;
      slowIsFirst <= 1'b1;
      pendAge <= '0;
      waitCnt <= '0;
    end else if (clearRun) begin
      pending <= 1'b0;
      waitCnt <= '0;
    end else if (slowRise & ~fastRise) begin
      pending <= 1'b1;
      slowIsFirst <= firstSlow;
      pendAge <= (ageOther == ageMax) ? ageOther : ageOther + 1'b1;
      waitCnt <= '0;
    end else if (fastRise) begin
      pending <= 1'b0;
    end else if (pending && waitCnt != ageMax) begin
      waitCnt <= waitCnt + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      singleResult <= '0;
      singleStrobe <= 1'b0;
      sum <= '0;
      sampleCnt <= '0;
      accumResult <= '0;
      accumValid <= 1'b0;
    end else begin
      singleStrobe <= emit;
      if (emit) singleResult <= nextSingle;
      if (clearRun) begin
        sum <= '0;
        sampleCnt <= '0;
        accumValid <= 1'b0; // [RQ21]
      end else if (setDone) begin
        accumResult <= nextSum;
        accumValid <= 1'b1; // [RQ8]
        sum <= '0;
        sampleCnt <= '0;
      end else if (emit) begin
        sum <= nextSum;
        sampleCnt <= sampleCnt + 1'b1;
      end
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  valid_after_set_a: assert property (setDone && !clearRun |=> accumValid) // [RQ8]
    else $error("valid flag not set after full sample set");
  valid_restart_a: assert property (restart |=> !accumValid) // [RQ21]
    else $error("valid flag survived restart");
  sign_first_lags_a: assert property (emit && !bothRise && positive |=>
    !singleResult[SINGLE_W-1]) // [RQ3]
    else $error("lagging first clock gave negative result");
  count_bound_a: assert property (sampleCnt < target || clearRun) // [RQ6]
    else $error("sample count ran past target");
  cover_full_set_c: cover property (setDone ##1 accumValid);
  cover_negative_c: cover property (emit && !positive && !bothRise);
endmodule : phase_pair_meter
`default_nettype wire

// *** input_clock_phase_tdc.sv ***
// Input clock phase measurement unit: ten conditioned channels, ten pairs, readout mux.
// Assumes input clocks are synchronous samples on sys_clk; settings arrive as plain ports.
`timescale 1ns/1ns
`default_nettype none
module input_clock_phase_tdc
  import tdc_pkg::*;
#(
  parameter int CHANNELS = NUM_CH,
  parameter int PAIRS = NUM_PAIR,
  parameter logic [DIV_W-1:0] MEAS_DIV = MEAS_DIV_DEFAULT
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Measured input clocks
  input wire logic [CHANNELS-1:0] inputClk,
  // Channel settings
  input wire logic [CHANNELS-1:0] analogChannelPowerdown,
  input wire logic [CHANNELS-1:0] inputPolarityInvert,
  // Pair settings
  input wire logic [PAIRS-1:0] digitalPairPowerup,
  input wire logic [PAIRS*SEL_W-1:0] pairFirstClockSelect,
  input wire logic [PAIRS*SEL_W-1:0] pairSecondClockSelect,
  input wire logic [PAIRS*EXP_W-1:0] sampleExponent,
  input wire logic measRefOscSelect,
  input wire logic [SEL_W-1:0] readoutPairSelect,
  // Self-clearing control bits, written by the host
  input wire logic applyWrite,
  input wire logic applyWriteData,
  input wire logic snapshotWrite,
  input wire logic snapshotWriteData,
  // Status and readback
  output logic applyConfiguration,
  output logic snapshotRequest,
  output logic [SINGLE_W-1:0] singleMeasurementResult,
  output logic [ACCUM_W-1:0] averagedPhaseResult,
  output logic averageValidFlag,
  output logic [DIV_W-1:0] measDividerReadback,
  output logic measRefSelectActive
);
  if (CHANNELS < 2 || CHANNELS > (1 << SEL_W)) begin : g_bad_channels
    $error("CHANNELS out of range");
  end
  if (PAIRS < 1 || PAIRS > (1 << SEL_W)) begin : g_bad_pairs
    $error("PAIRS out of range");
  end

  // Active settings: host writes other than readoutPairSelect take effect only through the apply bit
  logic [CHANNELS-1:0] activePowerdown, activeInvert, condClk;
  logic [PAIRS-1:0] activePowerup;
  logic [PAIRS*SEL_W-1:0] activeFirstSel, activeSecondSel;
  logic [PAIRS*EXP_W-1:0] activeExponent;
  logic snapshotCapture;

  wire loadConfig = applyConfiguration;
  wire applyRise = applyWrite & applyWriteData & ~applyConfiguration; // [RQ17]
  wire snapRise = snapshotWrite & snapshotWriteData & ~snapshotRequest; // [RQ9]

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      applyConfiguration <= 1'b0;
    end else begin
      applyConfiguration <= applyRise; // [RQ17]
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      activePowerdown <= PDN_RESET; // [RQ12]
      activeInvert <= POL_RESET;
      activePowerup <= PUP_RESET; // [RQ13]
      activeFirstSel <= {PAIRS{SEL_RESET}};
      activeSecondSel <= {PAIRS{SEL_RESET}};
      activeExponent <= {PAIRS{EXP_RESET}};
      measRefSelectActive <= 1'b0;
    end else if (loadConfig) begin
      activePowerdown <= analogChannelPowerdown;
      activeInvert <= inputPolarityInvert;
      activePowerup <= digitalPairPowerup;
      activeFirstSel <= pairFirstClockSelect; // [RQ14]
      activeSecondSel <= pairSecondClockSelect; // [RQ15]
      activeExponent <= sampleExponent;
      measRefSelectActive <= measRefOscSelect; // [RQ19]
    end
  end

  // A powered-down channel reads as a flat low level, so pairs on it stop updating
  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
      wire conditioned = (inputClk[ch] ^ activeInvert[ch]) & ~activePowerdown[ch]; // [RQ4] [RQ12]
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) condClk[ch] <= 1'b0;
        else condClk[ch] <= conditioned;
      end
    end
  endgenerate

  logic signed [SINGLE_W-1:0] pairSingle [PAIRS];
  logic signed [ACCUM_W-1:0] pairAccum [PAIRS];
  logic [PAIRS-1:0] pairValid;

  genvar p;
  generate
    for (p = 0; p < PAIRS; p++) begin : g_pair
      wire [SEL_W-1:0] firstSel = activeFirstSel[p*SEL_W +: SEL_W];
      wire [SEL_W-1:0] secondSel = activeSecondSel[p*SEL_W +: SEL_W];
      // Codes at or above the channel count select nothing rather than aliasing a channel
      wire firstClk = (int'(firstSel) < CHANNELS) ? condClk[firstSel] : 1'b0; // [RQ14] [RQ20]
      wire secondClk = (int'(secondSel) < CHANNELS) ? condClk[secondSel] : 1'b0; // [RQ15]
      phase_pair_meter u_meter (
        .sys_clk(sys_clk),
        .rst(rst),
        .pairEnable(activePowerup[p]),
        .restart(loadConfig),
        .sampleExponent(activeExponent[p*EXP_W +: EXP_W]),
        .firstClk(firstClk),
        .secondClk(secondClk),
        .singleResult(pairSingle[p]),
        .accumResult(pairAccum[p]),
        .accumValid(pairValid[p])
      ); // [RQ1] [RQ20]
    end
  endgenerate

  // Final readout mux
  wire selInRange = int'(readoutPairSelect) < PAIRS;
  wire [SINGLE_W-1:0] selSingle = selInRange ? pairSingle[readoutPairSelect] : '0; // [RQ16]
  wire [ACCUM_W-1:0] selAccum = selInRange ? pairAccum[readoutPairSelect] : '0;
  wire selValid = selInRange ? pairValid[readoutPairSelect] : 1'b0;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      snapshotRequest <= 1'b0;
      snapshotCapture <= 1'b0;
    end else begin
      snapshotCapture <= snapRise;
      if (snapRise) snapshotRequest <= 1'b1;
      else if (snapshotCapture) snapshotRequest <= 1'b0; // [RQ10]
    end
  end

  // Both results are taken on one edge so the host never sees a mixed pair
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      singleMeasurementResult <= '0;
      averagedPhaseResult <= '0;
    end else if (snapshotCapture) begin
      singleMeasurementResult <= selSingle; // [RQ9]
      averagedPhaseResult <= selAccum; // [RQ9]
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) averageValidFlag <= 1'b0;
    else averageValidFlag <= selValid; // [RQ8]
  end

  assign measDividerReadback = MEAS_DIV; // [RQ18]

  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  snap_clears_a: assert property (snapRise |=> snapshotRequest && snapshotCapture ##1
    !snapshotRequest) // [RQ10]
    else $error("snapshot request not cleared on the capture edge");
  snap_coherent_a: assert property (snapshotCapture |=>
    singleMeasurementResult == $past(selSingle) && averagedPhaseResult == $past(selAccum)) // [RQ9]
    else $error("snapshot results not captured together");
  snap_stable_a: assert property (!snapshotCapture |=> $stable(averagedPhaseResult)) // [RQ11]
    else $error("accumulated result changed without a snapshot");
  apply_pulse_a: assert property (applyRise |=> applyConfiguration ##1 !applyConfiguration) // [RQ17]
    else $error("apply bit not self-cleared");
  select_loaded_a: assert property (loadConfig |=> activeFirstSel == $past(pairFirstClockSelect)
    && activeSecondSel == $past(pairSecondClockSelect)) // [RQ14]
    else $error("clock selection not loaded on apply");
  pdn_silent_a: assert property (|activePowerdown |=> (condClk & $past(activePowerdown)) == '0) // [RQ12]
    else $error("powered-down channel still toggles");
  cover_snapshot_c: cover property (snapRise ##2 !snapshotRequest);
  cover_apply_c: cover property (applyRise ##1 loadConfig);
  cover_valid_c: cover property (!averageValidFlag ##1 averageValidFlag);
endmodule : input_clock_phase_tdc
`default_nettype wire

// *** clk_source_model.sv ***
// Far-side model: ten clocks aligned to sys_clk, each with its own period and delay.
// Assumes the bench sets periods that divide 65536 and keeps them steady in a run.
`timescale 1ns/1ns
`default_nettype none
module clk_source_model #(
  parameter int CH = 10
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Period and rising-edge delay per channel, in sys_clk cycles
  input wire logic [CH*8-1:0] chPeriod,
  input wire logic [CH*8-1:0] chDelay,
  // Generated clocks
  output logic [CH-1:0] inputClk
);
  logic [15:0] tick;

  // Periods are equal or integer multiples of each other
  function automatic logic level(input logic [15:0] t, input logic [7:0] per,
                                 input logic [7:0] dly);
    logic [15:0] ph;
    ph = (t + 16'(per) - 16'(dly)) % 16'(per);
    return ph < 16'(per >> 1);
  endfunction : level

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tick <= 16'h0000;
    end else begin
      tick <= tick + 16'h0001;
    end
  end

  always_comb begin
    for (int c = 0; c < CH; c++) begin
      inputClk[c] = level(tick, chPeriod[c*8+:8], chDelay[c*8+:8]);
    end
  end
endmodule : clk_source_model
`default_nettype wire

// *** tb_input_clock_phase_tdc.sv ***
// Self-checking bench for the input clock phase measurement unit.
// Assumes clk_source_model drives the clocks; settings are plain ports.
`timescale 1ns/1ns
`default_nettype none
module tb_input_clock_phase_tdc;
  import tdc_pkg::*;
  logic sys_clk, rst, measRefOscSelect, applyWrite, applyWriteData;
  logic snapshotWrite, snapshotWriteData, applyConfiguration, snapshotRequest;
  logic averageValidFlag, measRefSelectActive;
  logic [9:0] inputClk, analogChannelPowerdown, inputPolarityInvert, digitalPairPowerup;
  logic [39:0] pairFirstClockSelect, pairSecondClockSelect, sampleExponent;
  logic [3:0] readoutPairSelect;
  logic [35:0] singleMeasurementResult;
  logic [47:0] averagedPhaseResult;
  logic [7:0] measDividerReadback;
  logic [79:0] chPeriod, chDelay;
  int err_count, tests_run;

  input_clock_phase_tdc input_clock_phase_tdc_inst (.sys_clk(sys_clk), .rst(rst),
    .inputClk(inputClk), .analogChannelPowerdown(analogChannelPowerdown),
    .inputPolarityInvert(inputPolarityInvert), .digitalPairPowerup(digitalPairPowerup),
    .pairFirstClockSelect(pairFirstClockSelect), .pairSecondClockSelect(pairSecondClockSelect),
    .sampleExponent(sampleExponent), .measRefOscSelect(measRefOscSelect),
    .readoutPairSelect(readoutPairSelect), .applyWrite(applyWrite),
    .applyWriteData(applyWriteData), .snapshotWrite(snapshotWrite),
    .snapshotWriteData(snapshotWriteData), .applyConfiguration(applyConfiguration),
    .snapshotRequest(snapshotRequest), .singleMeasurementResult(singleMeasurementResult),
    .averagedPhaseResult(averagedPhaseResult), .averageValidFlag(averageValidFlag),
    .measDividerReadback(measDividerReadback), .measRefSelectActive(measRefSelectActive));
  clk_source_model clk_source_model_inst (.sys_clk(sys_clk), .rst(rst),
    .chPeriod(chPeriod), .chDelay(chDelay), .inputClk(inputClk));

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic check(input string what, input logic [47:0] seen, input logic [47:0] expected);
    tests_run++;
    if (seen !== expected) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", what, expected, seen);
    end
  endtask : check

  task automatic complete_run;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run

  task automatic applySettings;
    @(posedge sys_clk);
    applyWrite <= 1'b1;
    applyWriteData <= 1'b1;
    @(posedge sys_clk);
    applyWrite <= 1'b0;
    applyWriteData <= 1'b0;
    #1 check("apply set", {47'h0, applyConfiguration}, 48'h1);
    @(posedge sys_clk);
    #1 check("apply clear", {47'h0, applyConfiguration}, 48'h0);
    @(posedge sys_clk);
    #1 check("valid after apply", {47'h0, averageValidFlag}, 48'h0);
  endtask : applySettings

  task automatic takeSnapshot;
    int n;
    n = 0;
    @(posedge sys_clk);
    snapshotWrite <= 1'b1;
    snapshotWriteData <= 1'b1;
    @(posedge sys_clk);
    snapshotWrite <= 1'b0;
    snapshotWriteData <= 1'b0;
    #1 check("snapshot set", {47'h0, snapshotRequest}, 48'h1);
    while (snapshotRequest !== 1'b0 && n < 10) begin
      @(posedge sys_clk);
      #1 n++;
    end
    check("snapshot clear time", 48'(n), 48'd1);
  endtask : takeSnapshot

  task automatic measure(input logic [3:0] p, f, s, e, input logic [9:0] pol,
                         input logic [35:0] expS, input logic [47:0] expA);
    @(posedge sys_clk);
    digitalPairPowerup[p] <= 1'b1;
    pairFirstClockSelect[p*4+:4] <= f;
    pairSecondClockSelect[p*4+:4] <= s;
    sampleExponent[p*4+:4] <= e;
    inputPolarityInvert <= pol;
    readoutPairSelect <= p;
    applySettings;
    repeat (400) @(posedge sys_clk);
    #1 check("valid", {47'h0, averageValidFlag}, 48'h1);
    takeSnapshot;
    check("single", {12'h000, singleMeasurementResult}, {12'h000, expS});
    check("accum", averagedPhaseResult, expA);
  endtask : measure

  task automatic testReset;
    #1 check("reset single", {12'h000, singleMeasurementResult}, 48'h0);
    check("reset accum", averagedPhaseResult, 48'h0);
    check("reset valid", {47'h0, averageValidFlag}, 48'h0);
    check("divider", {40'h0, measDividerReadback}, {40'h0, MEAS_DIV_DEFAULT});
    @(posedge sys_clk);
    measRefOscSelect <= 1'b1;
    applySettings;
    check("osc select", {47'h0, measRefSelectActive}, 48'h1);
    $display("test reset done");
  endtask : testReset

  task automatic testLagLead;
    measure(4'h0, 4'h1, 4'h0, 4'h0, 10'h000, 36'h000000003, 48'h6);
    measure(4'h1, 4'h0, 4'h1, 4'h0, 10'h000, -36'sd3, -48'sd6);
    // A code past the last pair must read as invalid, not alias a live pair
    @(posedge sys_clk);
    readoutPairSelect <= 4'hC;
    repeat (2) @(posedge sys_clk);
    #1 check("valid unknown pair", {47'h0, averageValidFlag}, 48'h0);
    @(posedge sys_clk);
    readoutPairSelect <= 4'h5;
    repeat (5) @(posedge sys_clk);
    #1 check("held single", {12'h000, singleMeasurementResult}, {12'h000, -36'sd3});
    $display("test lag lead done");
  endtask : testLagLead

  task automatic testInvertRatio;
    measure(4'h2, 4'h1, 4'h0, 4'h0, 10'h002, -36'sd5, -48'sd10);
    measure(4'h3, 4'h2, 4'h0, 4'h0, 10'h000, -36'sd3, -48'sd6);
    measure(4'h0, 4'h1, 4'h0, 4'h2, 10'h000, 36'h000000003, 48'd24);
    $display("test invert ratio done");
  endtask : testInvertRatio

  task automatic testDisable;
    @(posedge sys_clk);
    analogChannelPowerdown <= 10'h002;
    readoutPairSelect <= 4'h0;
    applySettings;
    repeat (400) @(posedge sys_clk);
    #1 check("valid channel down", {47'h0, averageValidFlag}, 48'h0);
    @(posedge sys_clk);
    analogChannelPowerdown <= 10'h000;
    digitalPairPowerup <= 10'h000;
    applySettings;
    repeat (400) @(posedge sys_clk);
    #1 check("valid pair off", {47'h0, averageValidFlag}, 48'h0);
    $display("test disable done");
  endtask : testDisable

  initial begin
    rst = 1'b1;
    {measRefOscSelect, applyWrite, applyWriteData, snapshotWrite, snapshotWriteData} = 5'h00;
    {analogChannelPowerdown, inputPolarityInvert, digitalPairPowerup} = 30'h0;
    {pairFirstClockSelect, pairSecondClockSelect, sampleExponent} = 120'h0;
    readoutPairSelect = 4'h0;
    err_count = 0;
    tests_run = 0;
    chDelay = 80'h0;
    for (int c = 0; c < 10; c++) begin
      chPeriod[c*8+:8] = 8'h10;
    end
    chDelay[15:8] = 8'h03;
    chPeriod[23:16] = 8'h40;
    chDelay[23:16] = 8'h0D;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    testReset;
    testLagLead;
    testInvertRatio;
    testDisable;
    complete_run;
  end

  // Whole run is about 2900 cycles; a hang stops well past that
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    $display("watchdog expired");
    complete_run;
  end
endmodule : tb_input_clock_phase_tdc
`default_nettype wire
